// ==== cx_exec_regs.svh ====
// timing counts and field limits for the execution subset
// assumes one instruction cycle per core_clk edge
`ifndef CX_EXEC_REGS_SVH
`define CX_EXEC_REGS_SVH

// ------------------------------------------------------------
// cycle counts per operation class
// ------------------------------------------------------------
`define CX_CYC_ONE 5'h01
`define CX_CYC_LOOP 5'h02
`define CX_CYC_JUMP 5'h04
`define CX_CYC_DIV 5'h12
`define CX_CYC_SFR 5'h01

// ------------------------------------------------------------
// field widths and positions
// ------------------------------------------------------------
`define CX_HOLD_W 14
`define CX_LOOP_LIT_W 15
`define CX_SHIFT_LIT_W 5
`define CX_PC_W 23
`define CX_ACC_W 40
`define CX_ACC_SIGN 31
`define CX_BCD_LIMIT 4'h9
`define CX_BCD_FIX 4'h6

`endif

// ==== cx_pkg.sv ====
// types shared by the execution subset
// no timescale: package only
package cx_pkg;

	// ------------------------------------------------------------
	// operation select
	// ------------------------------------------------------------
	typedef enum logic [4:0] {
		CX_DECIMAL_ADJUST_OP = 5'h00,
		CX_INTERRUPT_HOLD_OP = 5'h01,
		CX_DIV_S16_OP = 5'h02,
		CX_DIV_S32_OP = 5'h03,
		CX_DIV_U16_OP = 5'h04,
		CX_DIV_U32_OP = 5'h05,
		CX_FRACTION_QUOTIENT_OP = 5'h06,
		CX_LOOP_LIT_OP = 5'h07,
		CX_LOOP_REG_OP = 5'h08,
		CX_EUCLID_DISTANCE_OP = 5'h09,
		CX_EUCLID_ACCUMULATE_OP = 5'h0A,
		CX_SIGN_CHANGE_SCAN_OP = 5'h0B,
		CX_LEADING_ONE_SCAN_OP = 5'h0C,
		CX_TRAILING_ONE_SCAN_OP = 5'h0D,
		CX_JUMP_DIRECT_OP = 5'h0E,
		CX_JUMP_INDIRECT_OP = 5'h0F,
		CX_JUMP_LONG_OP = 5'h10,
		CX_SHIFT_BY_REG_OP = 5'h11,
		CX_SHIFT_BY_LIT_OP = 5'h12,
		CX_SHIFT_ONE_OP = 5'h13
	} cx_op_t;

	// ------------------------------------------------------------
	// sequencer states
	// ------------------------------------------------------------
	typedef enum logic [0:0] {
		CX_IDLE = 1'b0,
		CX_EXEC = 1'b1
	} cx_state_t;

endpackage

// ==== cx_exec_core.sv ====
// execution unit for a subset of a 16-bit core's instructions
// assumes operands are stable on the issue cycle only
// Function
// - decimal adjust, one cycle, carry only
// - interrupt holdoff for literal cycle count
// - 16/16 divides take 18 cycles, NZCOV
// - 32/16 divides take 18 cycles, NZCOV
// - fractional divide with option, 18 cycles
// - literal loop, count plus one, two cycles
// - register loop, value plus one, two cycles
// - euclid distance one cycle, accumulator flags
// - sign change scan from msb, carry only
// - first-one scans either end, carry only
// - all jumps take four cycles, no flags
// - multi-bit right shift sets N,Z only
// - one-bit right shift sets C,N,OV,Z
// - peripheral register access adds one cycle
`timescale 1ns/1ps
`include "cx_exec_regs.svh"

module cx_exec_core import cx_pkg::*; (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic issue_valid,
	input wire cx_op_t issue_op,
	input wire logic [15:0] src_a,
	input wire logic [15:0] src_b,
	input wire logic [15:0] src_hi,
	input wire logic [15:0] literal,
	input wire logic [`CX_PC_W-1:0] jump_addr,
	input wire logic [`CX_PC_W-1:0] pc,
	input wire logic sfr_access,
	input wire logic acc_sel,
	input wire logic dsp_present,
	input wire logic half_carry_flag,
	input wire logic loop_pass_done,
	output logic issue_ready,
	output logic done_q,
	output logic illegal_q,
	output logic [15:0] result_q,
	output logic [15:0] result_hi_q,
	output logic flag_c_q,
	output logic flag_n_q,
	output logic flag_z_q,
	output logic arith_wrap_flag_q,
	output logic [`CX_ACC_W-1:0] acc_one_q,
	output logic [`CX_ACC_W-1:0] acc_two_q,
	output logic acc_one_overflow_q,
	output logic acc_two_overflow_q,
	output logic either_acc_overflow,
	output logic acc_one_clipped_q,
	output logic acc_two_clipped_q,
	output logic either_acc_clipped,
	output logic int_inhibit,
	output logic [`CX_HOLD_W-1:0] hold_left_q,
	output logic [16:0] loop_count_q,
	output logic [`CX_PC_W-1:0] loop_end_q,
	output logic loop_active,
	output logic pc_load_q,
	output logic [`CX_PC_W-1:0] pc_target_q
);

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	// position of first one from msb, 1..16, 0 when none
	function automatic logic [4:0] lead_pos(input logic [15:0] v);
		logic [4:0] p;
		p = 5'h00;
		for (int i = 0; i < 16; i++) begin
			if (v[i])
				p = 5'(16 - i);
		end
		return p;
	endfunction

	// base cycle count of each operation
	function automatic logic [4:0] base_cycles(input cx_op_t op);
		case (op)
			CX_DIV_S16_OP, CX_DIV_U16_OP: return `CX_CYC_DIV;
			CX_DIV_S32_OP, CX_DIV_U32_OP: return `CX_CYC_DIV;
			CX_FRACTION_QUOTIENT_OP: return `CX_CYC_DIV;
			CX_LOOP_LIT_OP, CX_LOOP_REG_OP: return `CX_CYC_LOOP;
			CX_JUMP_DIRECT_OP, CX_JUMP_INDIRECT_OP,
			CX_JUMP_LONG_OP: return `CX_CYC_JUMP;
			default: return `CX_CYC_ONE;
		endcase
	endfunction

	function automatic logic dsp_only(input cx_op_t op);
		case (op)
			CX_FRACTION_QUOTIENT_OP, CX_LOOP_LIT_OP, CX_LOOP_REG_OP,
			CX_EUCLID_DISTANCE_OP, CX_EUCLID_ACCUMULATE_OP: return 1'b1;
			default: return 1'b0;
		endcase
	endfunction

	// ------------------------------------------------------------
	// issue latch and sequencer
	// ------------------------------------------------------------
	cx_state_t state_q;
	cx_op_t op_q;
	logic [15:0] a_q, b_q, hi_q, lit_q;
	logic [`CX_PC_W-1:0] addr_q, pc_q;
	logic acc_sel_q, bad_q;
	logic [4:0] cnt_q;
	logic take, commit;

	assign issue_ready = (state_q == CX_IDLE);
	assign take = issue_valid && issue_ready;
	assign commit = (state_q == CX_EXEC) && (cnt_q == 5'h00);

	// operands held so the caller may move on after issue
	always_ff @(posedge core_clk) begin
		if (take) begin
			op_q <= issue_op;
			a_q <= src_a;
			b_q <= src_b;
			hi_q <= src_hi;
			lit_q <= literal;
			addr_q <= jump_addr;
			pc_q <= pc;
			acc_sel_q <= acc_sel;
			bad_q <= dsp_only(issue_op) && !dsp_present;
		end
	end

	// count down the documented cycles, plus one for peripherals
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			state_q <= CX_IDLE;
			cnt_q <= 5'h00;
		end else begin
			case (state_q)
				CX_IDLE: begin
					if (take) begin
						state_q <= CX_EXEC;
						cnt_q <= base_cycles(issue_op) - `CX_CYC_ONE
							+ (sfr_access ? `CX_CYC_SFR : 5'h00);
					end
				end
				CX_EXEC: begin
					if (cnt_q == 5'h00)
						state_q <= CX_IDLE;
					else
						cnt_q <= cnt_q - 5'h01;
				end
				default: state_q <= CX_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------
	// divide datapath (results only visible at commit)
	// ------------------------------------------------------------
	// a single wide divider; the 18-cycle hold hides its depth
	logic signed [32:0] dvd, dvs, quo, rem;
	logic sgn, div_zero, div_wrap;

	always_comb begin
		sgn = (op_q != CX_DIV_U16_OP) && (op_q != CX_DIV_U32_OP);
		case (op_q)
			CX_DIV_S32_OP: dvd = {hi_q[15], hi_q, a_q};
			CX_DIV_U32_OP: dvd = {1'b0, hi_q, a_q};
			CX_DIV_U16_OP: dvd = {17'h00000, a_q};
			CX_FRACTION_QUOTIENT_OP:
				dvd = {{2{a_q[15]}}, a_q, 15'h0000};
			default: dvd = {{17{a_q[15]}}, a_q};
		endcase
		dvs = sgn ? {{17{b_q[15]}}, b_q} : {17'h00000, b_q};
		div_zero = (b_q == 16'h0000);
		// both arms signed, else the divide quietly turns unsigned
		quo = div_zero ? 33'sh1FFFFFFFF : dvd / dvs;
		rem = div_zero ? 33'sh000000000 : dvd % dvs;
		if (div_zero)
			div_wrap = 1'b1;
		else if (sgn)
			div_wrap = (quo > 33'sh00007FFF) || (quo < -33'sh00008000);
		else
			div_wrap = (quo > 33'sh0000FFFF);
	end

	// ------------------------------------------------------------
	// single-cycle datapath
	// ------------------------------------------------------------
	logic [15:0] bcd, shr, res;
	logic bcd_c, lo_fix;
	logic [4:0] amt;
	logic signed [31:0] sq;
	logic signed [`CX_ACC_W:0] acc_sum;
	logic [`CX_ACC_W-1:0] acc_new;
	logic acc_clip, acc_ovf;

	always_comb begin
		// packed bcd correction of the low byte
		lo_fix = (a_q[3:0] > `CX_BCD_LIMIT) || half_carry_flag;
		bcd = a_q + (lo_fix ? {12'h000, `CX_BCD_FIX} : 16'h0000);
		bcd_c = flag_c_q || (bcd[7:4] > `CX_BCD_LIMIT);
		if (bcd_c)
			bcd = bcd + {8'h00, `CX_BCD_FIX, 4'h0};
		bcd = {8'h00, bcd[7:0]};
		// shift amounts of 16 and above clear the word
		amt = (op_q == CX_SHIFT_BY_REG_OP) ? b_q[4:0] :
			lit_q[`CX_SHIFT_LIT_W-1:0];
		shr = a_q >> amt;
		// euclid: square the difference, then load or add
		sq = $signed(a_q - b_q) * $signed(a_q - b_q);
		acc_sum = {{9{sq[31]}}, sq};
		if (op_q == CX_EUCLID_ACCUMULATE_OP)
			acc_sum = acc_sum + (acc_sel_q ? {acc_two_q[39], acc_two_q} :
				{acc_one_q[39], acc_one_q});
		// saturate instead of wrapping the 40-bit accumulator
		acc_clip = acc_sum[40] != acc_sum[39];
		if (acc_clip)
			acc_new = acc_sum[40] ? {1'b1, 39'h0} : {1'b0, {39{1'b1}}};
		else
			acc_new = acc_sum[39:0];
		acc_ovf = !(&acc_new[39:`CX_ACC_SIGN] || ~|acc_new[39:`CX_ACC_SIGN]);
		res = quo[15:0];
	end

	// ------------------------------------------------------------
	// commit: results and arithmetic flags
	// ------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			result_q <= 16'h0000;
			result_hi_q <= 16'h0000;
			flag_c_q <= 1'b0;
			flag_n_q <= 1'b0;
			flag_z_q <= 1'b0;
			arith_wrap_flag_q <= 1'b0;
		end else if (commit && !bad_q) begin
			case (op_q)
				CX_DECIMAL_ADJUST_OP: begin
					result_q <= bcd;
					flag_c_q <= bcd_c;
				end
				CX_DIV_S16_OP, CX_DIV_S32_OP, CX_DIV_U16_OP, CX_DIV_U32_OP,
				CX_FRACTION_QUOTIENT_OP: begin
					result_q <= res;
					result_hi_q <= rem[15:0];
					flag_n_q <= res[15];
					flag_z_q <= (res == 16'h0000);
					flag_c_q <= (rem != 33'h000000000);
					arith_wrap_flag_q <= div_wrap;
				end
				CX_EUCLID_DISTANCE_OP, CX_EUCLID_ACCUMULATE_OP:
					result_q <= a_q - b_q;
				CX_SIGN_CHANGE_SCAN_OP: begin
					// skip the sign bit, look for the first bit unlike it
					result_q <= {11'h000,
						lead_pos({1'b0, a_q[14:0] ^ {15{a_q[15]}}})};
					flag_c_q <= ~|(a_q[14:0] ^ {15{a_q[15]}});
				end
				CX_LEADING_ONE_SCAN_OP: begin
					result_q <= {11'h000, lead_pos(a_q)};
					flag_c_q <= (a_q == 16'h0000);
				end
				CX_TRAILING_ONE_SCAN_OP: begin
					result_q <= {11'h000, lead_pos({<<{a_q}})};
					flag_c_q <= (a_q == 16'h0000);
				end
				CX_SHIFT_BY_REG_OP, CX_SHIFT_BY_LIT_OP: begin
					result_q <= shr;
					flag_n_q <= shr[15];
					flag_z_q <= (shr == 16'h0000);
				end
				CX_SHIFT_ONE_OP: begin
					result_q <= {1'b0, a_q[15:1]};
					flag_c_q <= a_q[0];
					flag_n_q <= 1'b0;
					arith_wrap_flag_q <= 1'b0;
					flag_z_q <= (a_q[15:1] == 15'h0000);
				end
				default: ;
			endcase
		end
	end

	// completion and refusal pulses
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			done_q <= 1'b0;
			illegal_q <= 1'b0;
		end else begin
			done_q <= commit;
			illegal_q <= commit && bad_q;
		end
	end

	// ------------------------------------------------------------
	// accumulators and their status
	// ------------------------------------------------------------
	logic ed_commit;
	assign ed_commit = commit && !bad_q &&
		(op_q == CX_EUCLID_DISTANCE_OP || op_q == CX_EUCLID_ACCUMULATE_OP);

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			acc_one_q <= '0;
			acc_two_q <= '0;
			acc_one_overflow_q <= 1'b0;
			acc_two_overflow_q <= 1'b0;
			acc_one_clipped_q <= 1'b0;
			acc_two_clipped_q <= 1'b0;
		end else if (ed_commit) begin
			if (acc_sel_q) begin
				acc_two_q <= acc_new;
				acc_two_overflow_q <= acc_ovf;
				acc_two_clipped_q <= acc_clip;
			end else begin
				acc_one_q <= acc_new;
				acc_one_overflow_q <= acc_ovf;
				acc_one_clipped_q <= acc_clip;
			end
		end
	end

	assign either_acc_overflow = acc_one_overflow_q | acc_two_overflow_q;
	assign either_acc_clipped = acc_one_clipped_q | acc_two_clipped_q;

	// ------------------------------------------------------------
	// interrupt holdoff
	// ------------------------------------------------------------
	// a fresh load wins over the running count-down
	always_ff @(posedge core_clk) begin
		if (!rst_n)
			hold_left_q <= '0;
		else if (commit && op_q == CX_INTERRUPT_HOLD_OP)
			hold_left_q <= lit_q[`CX_HOLD_W-1:0];
		else if (hold_left_q != '0)
			hold_left_q <= hold_left_q - 14'h0001;
	end

	assign int_inhibit = (hold_left_q != '0);

	// ------------------------------------------------------------
	// hardware loop
	// ------------------------------------------------------------
	// a new loop start wins over a pass ending in the same cycle
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			loop_count_q <= 17'h00000;
			loop_end_q <= '0;
		end else if (commit && !bad_q && op_q == CX_LOOP_LIT_OP) begin
			loop_count_q <= {2'b00, lit_q[`CX_LOOP_LIT_W-1:0]} + 17'h00001;
			loop_end_q <= pc_q + {{7{b_q[15]}}, b_q};
		end else if (commit && !bad_q && op_q == CX_LOOP_REG_OP) begin
			loop_count_q <= {1'b0, a_q} + 17'h00001;
			loop_end_q <= pc_q + {{7{b_q[15]}}, b_q};
		end else if (loop_pass_done && loop_count_q != 17'h00000) begin
			loop_count_q <= loop_count_q - 17'h00001;
		end
	end

	assign loop_active = (loop_count_q != 17'h00000);

	// ------------------------------------------------------------
	// jumps
	// ------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			pc_load_q <= 1'b0;
			pc_target_q <= '0;
		end else begin
			pc_load_q <= 1'b0;
			if (commit) begin
				case (op_q)
					CX_JUMP_DIRECT_OP: begin
						pc_load_q <= 1'b1;
						pc_target_q <= addr_q;
					end
					CX_JUMP_INDIRECT_OP: begin
						pc_load_q <= 1'b1;
						pc_target_q <= {7'h00, a_q};
					end
					CX_JUMP_LONG_OP: begin
						pc_load_q <= 1'b1;
						pc_target_q <= {hi_q[6:0], a_q};
					end
					default: ;
				endcase
			end
		end
	end

endmodule

// ==== cx_exec_core_monitor.sv ====
// port-level assertions for the execution subset core
// assumes binding into cx_exec_core, one clock, sync active-low reset
`timescale 1ns/1ps
`include "cx_exec_regs.svh"

module cx_exec_core_monitor import cx_pkg::*; (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic issue_valid,
	input wire cx_op_t issue_op,
	input wire logic [15:0] src_a,
	input wire logic [15:0] literal,
	input wire logic sfr_access,
	input wire logic dsp_present,
	input wire logic issue_ready,
	input wire logic done_q,
	input wire logic illegal_q,
	input wire logic [15:0] result_q,
	input wire logic flag_c_q,
	input wire logic flag_n_q,
	input wire logic flag_z_q,
	input wire logic arith_wrap_flag_q,
	input wire logic acc_one_overflow_q,
	input wire logic acc_two_overflow_q,
	input wire logic either_acc_overflow,
	input wire logic [`CX_HOLD_W-1:0] hold_left_q,
	input wire logic [16:0] loop_count_q,
	input wire logic loop_active,
	input wire logic pc_load_q
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	// take without the peripheral penalty, so counts are the listed ones
	logic take;
	logic one_cyc;
	logic [3:0] flags;
	logic int_hold_ok;
	logic [`CX_HOLD_W-1:0] hold_prev_q;
	assign take = issue_valid && issue_ready && !sfr_access;
	assign one_cyc = issue_op inside {CX_SHIFT_ONE_OP, CX_SHIFT_BY_LIT_OP,
		CX_SHIFT_BY_REG_OP, CX_LEADING_ONE_SCAN_OP, CX_DECIMAL_ADJUST_OP,
		CX_TRAILING_ONE_SCAN_OP, CX_SIGN_CHANGE_SCAN_OP};
	assign flags = {flag_c_q, flag_n_q, flag_z_q, arith_wrap_flag_q};

	// decrement check kept in a helper so the property stays readable
	always_ff @(posedge core_clk) begin
		hold_prev_q <= hold_left_q;
	end
	assign int_hold_ok = hold_left_q == hold_prev_q - 14'h0001;

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	a_reset_idle_state: assert property ($past(!rst_n) |-> issue_ready &&
		!done_q && !pc_load_q && hold_left_q == 14'h0000)
		else $error("state after reset not idle");
	a_take_goes_busy: assert property (issue_valid && issue_ready |=>
		!issue_ready) else $error("request taken but still ready");
	a_single_cycle_time: assert property (
		take && one_cyc |-> ##1 !issue_ready ##1 issue_ready && done_q)
		else $error("one-cycle op timing");
	a_divide_eighteen_cycles: assert property (
		take && issue_op inside
		{CX_DIV_S16_OP, CX_DIV_S32_OP, CX_DIV_U16_OP, CX_DIV_U32_OP} |->
		##18 !issue_ready ##1 issue_ready && done_q)
		else $error("divide not eighteen cycles");
	a_fraction_refused: assert property (
		take && !dsp_present &&
		issue_op == CX_FRACTION_QUOTIENT_OP |-> ##19 done_q && illegal_q)
		else $error("fraction divide without option not refused");
	a_loop_lit_count: assert property (take && dsp_present &&
		issue_op == CX_LOOP_LIT_OP |-> ##3
		loop_count_q == {2'h0, $past(literal[14:0], 3)} + 17'h00001)
		else $error("literal loop count wrong");
	a_jump_four_cycles: assert property (take && issue_op inside
		{CX_JUMP_DIRECT_OP, CX_JUMP_INDIRECT_OP, CX_JUMP_LONG_OP} |=>
		$stable(flags) [*5] ##0 pc_load_q)
		else $error("jump timing or flags");
	a_sfr_extra_cycle: assert property (issue_valid && issue_ready &&
		sfr_access && one_cyc |-> ##2 !issue_ready ##1 issue_ready)
		else $error("peripheral access lacks extra cycle");
	a_hold_loaded: assert property (take &&
		issue_op == CX_INTERRUPT_HOLD_OP |-> ##2
		hold_left_q == $past(literal[`CX_HOLD_W-1:0], 2))
		else $error("holdoff count not loaded");
	a_hold_counts_down: assert property (
		hold_left_q != 14'h0000 && issue_ready && !issue_valid
		|=> int_hold_ok)
		else $error("holdoff count not decremented");
	a_shift_one_flags: assert property (take &&
		issue_op == CX_SHIFT_ONE_OP |-> ##2 result_q == $past(src_a, 2) >> 1
		&& flag_c_q == $past(src_a[0], 2) && !flag_n_q &&
		flag_z_q == (result_q == 16'h0000)) else $error("one-bit shift");
	a_either_acc_flag: assert property (either_acc_overflow ==
		(acc_one_overflow_q || acc_two_overflow_q))
		else $error("combined overflow flag");
	a_loop_active_level: assert property (loop_active ==
		(loop_count_q != 17'h00000)) else $error("loop active level");
endmodule

bind cx_exec_core cx_exec_core_monitor mon (.core_clk, .rst_n, .issue_valid,
	.issue_op, .src_a, .literal, .sfr_access, .dsp_present, .issue_ready,
	.done_q, .illegal_q, .result_q, .flag_c_q, .flag_n_q, .flag_z_q,
	.arith_wrap_flag_q, .acc_one_overflow_q, .acc_two_overflow_q,
	.either_acc_overflow, .hold_left_q, .loop_count_q, .loop_active,
	.pc_load_q);

// ==== cx_exec_core_tb.sv ====
// self-checking bench for the execution subset core
// assumes the monitor is bound in; inputs move on the falling edge
`timescale 1ns/1ps
`include "cx_exec_regs.svh"

module cx_exec_core_tb import cx_pkg::*; ;
	logic core_clk, rst_n, issue_valid, sfr_access, acc_sel, dsp_present;
	logic half_carry_flag, loop_pass_done;
	cx_op_t issue_op;
	logic [15:0] src_a, src_b, src_hi, literal, result_q, result_hi_q;
	logic [`CX_PC_W-1:0] jump_addr, pc, loop_end_q, pc_target_q;
	logic issue_ready, done_q, illegal_q, flag_c_q, flag_n_q, flag_z_q;
	logic arith_wrap_flag_q, acc_one_overflow_q, acc_two_overflow_q;
	logic either_acc_overflow, acc_one_clipped_q, acc_two_clipped_q;
	logic either_acc_clipped, int_inhibit, loop_active, pc_load_q;
	logic [`CX_ACC_W-1:0] acc_one_q, acc_two_q;
	logic [`CX_HOLD_W-1:0] hold_left_q;
	logic [16:0] loop_count_q;
	int error_cnt = 0;
	int num_checks = 0;
	int lat;
	logic [31:0] seed = 32'h00000021;

	cx_exec_core DUT (.core_clk, .rst_n, .issue_valid, .issue_op, .src_a,
		.src_b, .src_hi, .literal, .jump_addr, .pc, .sfr_access, .acc_sel,
		.dsp_present, .half_carry_flag, .loop_pass_done, .issue_ready,
		.done_q, .illegal_q, .result_q, .result_hi_q, .flag_c_q, .flag_n_q,
		.flag_z_q, .arith_wrap_flag_q, .acc_one_q, .acc_two_q,
		.acc_one_overflow_q, .acc_two_overflow_q, .either_acc_overflow,
		.acc_one_clipped_q, .acc_two_clipped_q, .either_acc_clipped,
		.int_inhibit, .hold_left_q, .loop_count_q, .loop_end_q,
		.loop_active, .pc_load_q, .pc_target_q);

	// ------------------------------------------------------------
	// clock and helpers
	// ------------------------------------------------------------
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	// xorshift keeps the run repeatable without tool-specific seeding
	function automatic logic [31:0] nxt();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	// listed cycle count plus the peripheral penalty
	function automatic int cycles(cx_op_t op, logic sfr);
		int n;
		n = 1;
		if (op inside {[CX_DIV_S16_OP:CX_FRACTION_QUOTIENT_OP]})
			n = 18;
		if (op inside {CX_LOOP_LIT_OP, CX_LOOP_REG_OP})
			n = 2;
		if (op inside {[CX_JUMP_DIRECT_OP:CX_JUMP_LONG_OP]})
			n = 4;
		return n + int'(sfr);
	endfunction

	// carry and position of the first one; none found gives C set
	function automatic logic [16:0] scan(logic [15:0] v, logic msb);
		scan = 17'h10000;
		// last hit wins: the top one, or the bottom one when msb is low
		for (int i = 0; i < 16; i++) begin
			if (v[msb ? i : 15 - i])
				scan = {1'b0, 16'(16 - i)};
		end
	endfunction

	task automatic chk(string name, logic [63:0] seen, logic [63:0] exp);
		num_checks++;
		if (seen !== exp) begin
			$display("[FAIL] %s exp %h seen %h", name, exp, seen);
			error_cnt++;
		end
	endtask

	task automatic complete_run();
		if (error_cnt == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// one request, held for one rising edge, then wait for done with a bound
	task automatic run(cx_op_t op, logic [15:0] a, b, hi, lit, logic sfr);
		issue_op = op;
		src_a = a;
		src_b = b;
		src_hi = hi;
		literal = lit;
		sfr_access = sfr;
		issue_valid = 1'b1;
		@(posedge core_clk);
		@(negedge core_clk);
		issue_valid = 1'b0;
		lat = 1;
		while (done_q !== 1'b1) begin
			@(negedge core_clk);
			lat++;
			if (lat > 60) begin
				error_cnt++;
				complete_run();
			end
		end
	endtask

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin : main
		logic [31:0] r;
		logic [15:0] a, b, hi, lit, lo;
		logic c0;
		cx_op_t op;
		{issue_valid, sfr_access, acc_sel, half_carry_flag} = 4'h0;
		{src_a, src_b, src_hi, literal, loop_pass_done} = 65'h0;
		{jump_addr, pc} = 46'h0;
		issue_op = CX_DECIMAL_ADJUST_OP;
		dsp_present = 1'b1;
		rst_n = 1'b0;
		repeat (2) @(negedge core_clk);
		rst_n = 1'b1;
		chk("ready", issue_ready, 1);
		// packed BCD with the low nibble over nine and a nine above it wraps to zero, C set
		run(CX_DECIMAL_ADJUST_OP, 16'h009A, 16'h0, 16'h0, 16'h0, 1'b0);
		chk("daw", {flag_c_q, result_q}, 17'h10000);
		// random mix of every code with operand checks
		for (int k = 0; k < 70; k++) begin
			r = nxt();
			op = cx_op_t'(5'(k < 20 ? k : r % 20));
			a = r[15:0];
			r = nxt();
			b = r[15:0] | 16'h0001;
			hi = r[31:16] % b;
			lit = r[31:16];
			half_carry_flag = r[3];
			acc_sel = r[4];
			jump_addr = 23'(nxt());
			pc = 23'(nxt());
			c0 = flag_c_q;
			run(op, a, b, hi, lit, r[7]);
			chk("cycles", lat, cycles(op, r[7]) + 1);
			lo = a >> lit[4:0];
			case (op)
			CX_SHIFT_ONE_OP:
				chk("lsr1", {flag_c_q, flag_z_q, result_q},
					{a[0], a[15:1] == 15'h0, a >> 1});
			CX_SHIFT_BY_LIT_OP:
				chk("lsrl", {flag_c_q, flag_z_q, result_q},
					{c0, lo == 16'h0, lo});
			CX_SHIFT_BY_REG_OP:
				chk("lsrr", {flag_c_q, result_q}, {c0, a >> b[4:0]});
			CX_LEADING_ONE_SCAN_OP:
				chk("leading_one_scan_op", {flag_c_q, result_q}, scan(a, 1'b1));
			CX_TRAILING_ONE_SCAN_OP:
				chk("trailing_one_scan_op", {flag_c_q, result_q}, scan(a, 1'b0));
			CX_SIGN_CHANGE_SCAN_OP:
				chk("sign_change_scan_op", {flag_c_q, result_q},
					scan((a ^ {16{a[15]}}) & 16'h7FFF, 1'b1));
			CX_DIV_U16_OP:
				chk("divu", {flag_c_q, result_hi_q, result_q},
					{a % b != 0, a % b, a / b});
			CX_DIV_U32_OP:
				chk("divud", {result_hi_q, result_q},
					{16'({hi, a} % b), 16'({hi, a} / b)});
			CX_JUMP_DIRECT_OP:
				chk("jd", pc_target_q, jump_addr);
			CX_JUMP_INDIRECT_OP:
				chk("ji", pc_target_q, {7'h00, a});
			CX_JUMP_LONG_OP:
				chk("jl", pc_target_q, {hi[6:0], a});
			CX_LOOP_LIT_OP:
				chk("dol", {loop_end_q, loop_count_q}, {pc + {{7{b[15]}}, b},
					{2'h0, lit[14:0]} + 17'h1});
			CX_LOOP_REG_OP:
				chk("dor", loop_count_q, {1'b0, a} + 17'h1);
			CX_INTERRUPT_HOLD_OP:
				chk("hold", {int_inhibit, hold_left_q},
					{lit[13:0] != 14'h0, lit[13:0]});
			default: ;
			endcase
		end
		// zero divisor corner
		run(CX_DIV_U16_OP, 16'h0005, 16'h0000, 16'h0, 16'h0, 1'b0);
		chk("div0", {arith_wrap_flag_q, result_q}, 17'h1FFFF);
		// euclid without then with accumulation
		acc_sel = 1'b0;
		run(CX_EUCLID_DISTANCE_OP, 16'h0005, 16'h0002, 16'h0, 16'h0, 1'b0);
		chk("ed", {result_q, acc_one_q}, {16'h0003, 40'h9});
		run(CX_EUCLID_ACCUMULATE_OP, 16'h0005, 16'h0002, 16'h0, 16'h0, 1'b0);
		chk("euclid_accumulate_op", acc_one_q, 40'h12);
		// a large square accumulated twice crosses bit 31
		run(CX_EUCLID_DISTANCE_OP, 16'h4000, 16'hC000, 16'h0, 16'h0, 1'b0);
		run(CX_EUCLID_ACCUMULATE_OP, 16'h4000, 16'hC000, 16'h0, 16'h0, 1'b0);
		chk("edov", {either_acc_overflow, acc_one_overflow_q, acc_one_q},
			{2'b11, 40'h0080000000});
		// a loop pass pulse lowers the count by one
		run(CX_LOOP_LIT_OP, 16'h0, 16'h0004, 16'h0, 16'h0002, 1'b0);
		loop_pass_done = 1'b1;
		@(negedge core_clk);
		loop_pass_done = 1'b0;
		chk("pass", {loop_active, loop_count_q}, 18'h20002);
		// without the option the signal-processing codes are refused
		dsp_present = 1'b0;
		run(CX_FRACTION_QUOTIENT_OP, 16'h1, 16'h2, 16'h0, 16'h0, 1'b0);
		chk("frac", {illegal_q, 8'(lat)}, {1'b1, 8'h13});
		run(CX_LOOP_LIT_OP, 16'h0, 16'h0, 16'h0, 16'h0007, 1'b0);
		chk("dsp", {illegal_q, loop_count_q}, {1'b1, 17'h2});
		dsp_present = 1'b1;
		// second reset in mid-run clears results
		rst_n = 1'b0;
		@(negedge core_clk);
		rst_n = 1'b1;
		chk("rst", {issue_ready, done_q, result_q}, {2'b10, 16'h0});
		// first request straight after the release is taken
		run(CX_SHIFT_ONE_OP, 16'h0003, 16'h0, 16'h0, 16'h0, 1'b0);
		chk("lsr1r", {flag_c_q, result_q}, 17'h10001);
		complete_run();
	end
endmodule
